/* logic/ttcd_top.sv */
`timescale 1ns/10ps
`default_nettype none
module ttcd_top
  import ttcd_pkg::*;
#(
  parameter int unsigned FREE_CYCLES = TTCD_FREE_CYC
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        nv_por_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        band_in_use,
  input  wire logic        supply_monitor_pin_tied,
  input  wire logic        reduced_variant,
  output logic             comm_ready,
  output logic             band_a,
  output logic             access_en,
  output logic             pm_selected,
  output logic             pm_active,
  output logic             core_clk_sel_a,
  output logic             tx_allowed
);
  localparam logic [TTCD_FREE_W-1:0] FREE_LIM = FREE_CYCLES[TTCD_FREE_W-1:0];

  function automatic logic [7:0] set_byte(input logic [55:0] s,
                                          input int i);
    set_byte = s[55-8*i -: 8];
  endfunction

  // Storage: survives presetn, its own power-on and the restore state load the factory set
  logic [7:0]             nv_reg [TTCD_NBYTES];
  logic [7:0]             nv_next [TTCD_NBYTES];
  logic [7:0]             shad_reg [TTCD_NBYTES];
  logic [7:0]             shad_next [TTCD_NBYTES];
  logic [55:0]            shad_vec;
  ttcd_state_t            state_reg, state_next;
  logic [2:0]             idx_reg, idx_next;
  logic [2:0]             settle_reg, settle_next;
  logic                   band_a_reg, band_a_next;
  logic                   access_reg, access_next;
  logic                   pm_sel_reg, pm_sel_next;
  logic                   dflt_reg, dflt_next;
  logic                   pm_act_reg, pm_act_next;
  logic                   tx_ok_reg, tx_ok_next;
  logic [TTCD_FREE_W-1:0] free_reg, free_next;
  logic [2:0]             s1_reg, s2_reg, s3_reg, filt_reg, filt_next;
  logic [31:0]            prdata_reg, prdata_next;
  logic                   dec_band_a, dec_access, dec_pm, dec_match;
  logic                   addr_ok, wr_en, setup_rd, node_rst_cmd;

  // APB decode, zero wait states
  always_comb begin
    addr_ok = (paddr == TTCD_OFF_PARAM_LO) || (paddr == TTCD_OFF_PARAM_HI) ||
              (paddr == TTCD_OFF_CTRL) || (paddr == TTCD_OFF_STATUS);
  end
  assign pready       = 1'b1;
  assign pslverr      = psel & penable & ~addr_ok;
  assign wr_en        = psel & penable & pwrite & addr_ok;
  assign setup_rd     = psel & ~penable & ~pwrite;
  assign node_rst_cmd = wr_en && (paddr == TTCD_OFF_CTRL) &&
                        pwdata[TTCD_CTRL_NODE_RST];

  always_comb begin
    prdata_next = prdata_reg;
    if (setup_rd) begin
      prdata_next = 32'h00000000;
      case (paddr)
        TTCD_OFF_PARAM_LO: prdata_next = {nv_reg[3], nv_reg[2],
                                          nv_reg[1], nv_reg[0]};
        TTCD_OFF_PARAM_HI: prdata_next = {8'h00, nv_reg[6],
                                          nv_reg[5], nv_reg[4]};
        TTCD_OFF_STATUS: begin
          prdata_next[TTCD_ST_READY]     = comm_ready;
          prdata_next[TTCD_ST_BAND_A]    = band_a_reg;
          prdata_next[TTCD_ST_ACCESS]    = access_reg;
          prdata_next[TTCD_ST_PM_SEL]    = pm_sel_reg;
          prdata_next[TTCD_ST_PM_ACT]    = pm_act_reg;
          prdata_next[TTCD_ST_DEFAULTED] = dflt_reg;
          prdata_next[TTCD_ST_TX_OK]     = tx_ok_reg;
          prdata_next[TTCD_ST_BAND_BUSY] = filt_reg[TTCD_PIN_BUSY];
          prdata_next[TTCD_ST_REDUCED]   = filt_reg[TTCD_PIN_REDUCED];
        end
        default: prdata_next = 32'h00000000;
      endcase
    end
  end

  // Programming path into storage
  always_comb begin
    for (int i = 0; i < TTCD_NBYTES; i++) begin
      nv_next[i] = nv_reg[i];
    end
    if (state_reg == TTCD_S_RESTORE) begin
      for (int i = 0; i < TTCD_NBYTES; i++) begin
        nv_next[i] = set_byte(TTCD_SET_FACTORY, i);
      end
    end else if (wr_en && (paddr == TTCD_OFF_PARAM_LO)) begin
      for (int i = 0; i < 4; i++) begin
        nv_next[i] = pwdata[8*i +: 8];
      end
    end else if (wr_en && (paddr == TTCD_OFF_PARAM_HI)) begin
      for (int i = 4; i < TTCD_NBYTES; i++) begin
        nv_next[i] = pwdata[8*(i-4) +: 8];
      end
    end
  end

  always_ff @(posedge pclk or negedge nv_por_n) begin
    if (!nv_por_n) begin
      for (int i = 0; i < TTCD_NBYTES; i++) begin
        nv_reg[i] <= set_byte(TTCD_SET_FACTORY, i);
      end
    end else begin
      for (int i = 0; i < TTCD_NBYTES; i++) begin
        nv_reg[i] <= nv_next[i];
      end
    end
  end

  // Pin filter: change taken once stages two and three agree
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      filt_next[i] = (s2_reg[i] == s3_reg[i]) ? s3_reg[i] : filt_reg[i];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_reg   <= TTCD_PIN_RST;
      s2_reg   <= TTCD_PIN_RST;
      s3_reg   <= TTCD_PIN_RST;
      filt_reg <= TTCD_PIN_RST;
    end else begin
      s1_reg   <= {reduced_variant, supply_monitor_pin_tied, band_in_use};
      s2_reg   <= s1_reg;
      s3_reg   <= s2_reg;
      filt_reg <= filt_next;
    end
  end

  always_comb begin
    for (int i = 0; i < TTCD_NBYTES; i++) begin
      shad_vec[55-8*i -: 8] = shad_reg[i];
    end
  end

  ttcd_decode u_decode (
    .param_set (shad_vec),
    .reduced   (filt_reg[TTCD_PIN_REDUCED]),
    .band_a    (dec_band_a),
    .access_en (dec_access),
    .pm_sel    (dec_pm),
    .matched   (dec_match)
  );

  // Load sequencer
  always_comb begin
    state_next  = state_reg;
    idx_next    = idx_reg;
    settle_next = settle_reg;
    band_a_next = band_a_reg;
    access_next = access_reg;
    pm_sel_next = pm_sel_reg;
    dflt_next   = dflt_reg;
    for (int i = 0; i < TTCD_NBYTES; i++) begin
      shad_next[i] = shad_reg[i];
    end
    case (state_reg)
      // Settle lets the strap filters catch the pins first
      TTCD_S_SETTLE: begin
        if (settle_reg == TTCD_SETTLE_CYC - 3'h1) begin
          state_next = TTCD_S_LOAD;
          idx_next   = 3'h0;
        end else begin
          settle_next = settle_reg + 3'h1;
        end
      end
      // read one byte per cycle, then latch
      TTCD_S_LOAD: begin
        if (idx_reg == TTCD_IDX_LATCH) begin
          state_next  = TTCD_S_RUN;
          band_a_next = dec_band_a;
          access_next = dec_access & ~dec_band_a;
          pm_sel_next = dec_pm;
          dflt_next   = ~dec_match;
        end else begin
          shad_next[idx_reg] = nv_reg[idx_reg];
          idx_next           = idx_reg + 3'h1;
        end
      end
      TTCD_S_RUN: begin
        state_next = TTCD_S_RUN;
      end
      TTCD_S_RESTORE: begin
        state_next = TTCD_S_SETTLE;
      end
      default: begin
        state_next = TTCD_S_SETTLE;
      end
    endcase
    if (node_rst_cmd) begin
      // byte one zero turns reset into reboot
      // otherwise the stored set is kept
      state_next  = (nv_reg[1] == 8'h00) ? TTCD_S_RESTORE : TTCD_S_SETTLE;
      settle_next = 3'h0;
      idx_next    = 3'h0;
      band_a_next = 1'b0;
      access_next = 1'b0;
      pm_sel_next = 1'b0;
      dflt_next   = 1'b0;
    end
  end

  // band must stay free for the full window
  always_comb begin
    free_next = free_reg;
    if (filt_reg[TTCD_PIN_BUSY] || !access_reg || state_reg != TTCD_S_RUN) begin
      free_next = '0;
    end else if (free_reg != FREE_LIM) begin
      free_next = free_reg + 1'b1;
    end
    tx_ok_next  = (state_reg == TTCD_S_RUN) && !node_rst_cmd &&
                  (!access_reg || free_reg == FREE_LIM);
    // divider wiring and pm set both needed
    pm_act_next = (state_reg == TTCD_S_RUN) && !node_rst_cmd &&
                  pm_sel_reg && !filt_reg[TTCD_PIN_TIED];
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg  <= TTCD_S_SETTLE;
      idx_reg    <= 3'h0;
      settle_reg <= 3'h0;
      band_a_reg <= 1'b0;
      access_reg <= 1'b0;
      pm_sel_reg <= 1'b0;
      dflt_reg   <= 1'b0;
      pm_act_reg <= 1'b0;
      tx_ok_reg  <= 1'b0;
      free_reg   <= '0;
      prdata_reg <= 32'h00000000;
      for (int i = 0; i < TTCD_NBYTES; i++) begin
        shad_reg[i] <= 8'h00;
      end
    end else begin
      state_reg  <= state_next;
      idx_reg    <= idx_next;
      settle_reg <= settle_next;
      band_a_reg <= band_a_next;
      access_reg <= access_next;
      pm_sel_reg <= pm_sel_next;
      dflt_reg   <= dflt_next;
      pm_act_reg <= pm_act_next;
      tx_ok_reg  <= tx_ok_next;
      free_reg   <= free_next;
      prdata_reg <= prdata_next;
      for (int i = 0; i < TTCD_NBYTES; i++) begin
        shad_reg[i] <= shad_next[i];
      end
    end
  end

  assign prdata      = prdata_reg;
  assign comm_ready  = (state_reg == TTCD_S_RUN);
  assign band_a      = band_a_reg;
  assign access_en   = access_reg;
  assign pm_selected = pm_sel_reg;
  assign pm_active   = pm_act_reg;
  assign tx_allowed  = tx_ok_reg;
  assign core_clk_sel_a = band_a_reg;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic latch_cyc;
  assign latch_cyc = (state_reg == TTCD_S_LOAD) && (idx_reg == TTCD_IDX_LATCH)
                     && !node_rst_cmd;

  sequence reboot_req;
    node_rst_cmd && (nv_reg[1] == 8'h00);
  endsequence
  sequence plain_rst_req;
    node_rst_cmd && (nv_reg[1] != 8'h00);
  endsequence

  a_factory_decode: assert property (
    latch_cyc && shad_vec == TTCD_SET_C_PLAIN |=>
      !band_a && !access_en && !pm_selected && !dflt_reg)
    else $error("factory set decoded wrong");
  a_access_decode: assert property (
    latch_cyc && shad_vec == TTCD_SET_C_ACC |=>
      !band_a && access_en && !pm_selected && comm_ready)
    else $error("access set decoded wrong");
  a_cband_pm_decode: assert property (
    latch_cyc && shad_vec == TTCD_SET_C_PLAINPM |=>
      !band_a && !access_en && pm_selected)
    else $error("C-band pm set decoded wrong");
  a_aband_decode: assert property (
    latch_cyc && shad_vec == TTCD_SET_A_PLAIN && !filt_reg[TTCD_PIN_REDUCED]
      |=> band_a && core_clk_sel_a && !access_en && !pm_selected)
    else $error("A-band set decoded wrong");
  a_aband_pm_decode: assert property (
    latch_cyc && shad_vec == TTCD_SET_A_PM && !filt_reg[TTCD_PIN_REDUCED]
      |=> band_a && !access_en && pm_selected)
    else $error("A-band pm set decoded wrong");
  a_pm_gate: assert property (
    pm_active |-> pm_selected && $past(!filt_reg[TTCD_PIN_TIED]))
    else $error("pm active without divider or pm set");
  a_aband_no_block: assert property (
    comm_ready && band_a && !node_rst_cmd |=> tx_allowed && !access_en)
    else $error("A-band transmission blocked");
  a_free_wait: assert property (
    tx_allowed && access_en |-> $past(free_reg) == FREE_LIM)
    else $error("transmit before band free window");
  a_reboot_seq: assert property (
    reboot_req |=> state_reg == TTCD_S_RESTORE && !comm_ready
      ##1 nv_reg[0] == set_byte(TTCD_SET_FACTORY, 0) &&
          nv_reg[1] == set_byte(TTCD_SET_FACTORY, 1))
    else $error("reboot did not restore factory set");
  a_reset_keeps: assert property (
    plain_rst_req |=> state_reg == TTCD_S_SETTLE ##1
      nv_reg[1] == $past(nv_reg[1], 2))
    else $error("plain reset changed stored set");
  a_reduced_c_only: assert property (
    filt_reg[TTCD_PIN_REDUCED] && latch_cyc |=> !band_a)
    else $error("reduced part ran A-band");
  a_unknown_dflt: assert property (
    latch_cyc && !dec_match |=> dflt_reg && !band_a && !access_en && !pm_selected)
    else $error("unknown set not treated as factory");
  a_load_bound: assert property (
    state_reg == TTCD_S_SETTLE && settle_reg == 3'h0 && !node_rst_cmd
      |-> ##[1:14] (comm_ready || node_rst_cmd))
    else $error("load sequence did not finish");
endmodule
`default_nettype wire

/* logic/ttcd_pkg.sv */
`default_nettype none
package ttcd_pkg;
  // Parameter set: byte 0 in bits 55:48, byte 6 in bits 7:0
  localparam int          TTCD_NBYTES        = 7;
  localparam logic [55:0] TTCD_SET_C_PLAIN   = 56'h0E010010000000;
  localparam logic [55:0] TTCD_SET_C_ACC     = 56'h4A000010000000;
  localparam logic [55:0] TTCD_SET_C_PLAINPM = 56'h0E010012000000;
  localparam logic [55:0] TTCD_SET_C_ACCPM   = 56'h4A000012000000;
  localparam logic [55:0] TTCD_SET_A_PLAIN   = 56'h0E010010000100;
  localparam logic [55:0] TTCD_SET_A_PM      = 56'h0E010012000100;
  localparam logic [55:0] TTCD_SET_FACTORY   = TTCD_SET_C_PLAIN;

  // APB byte offsets
  localparam logic [7:0]  TTCD_OFF_PARAM_LO  = 8'h00;
  localparam logic [7:0]  TTCD_OFF_PARAM_HI  = 8'h04;
  localparam logic [7:0]  TTCD_OFF_CTRL      = 8'h08;
  localparam logic [7:0]  TTCD_OFF_STATUS    = 8'h0C;

  // Field positions
  localparam int          TTCD_CTRL_NODE_RST = 0;
  localparam int          TTCD_ST_READY      = 0;
  localparam int          TTCD_ST_BAND_A     = 1;
  localparam int          TTCD_ST_ACCESS     = 2;
  localparam int          TTCD_ST_PM_SEL     = 3;
  localparam int          TTCD_ST_PM_ACT     = 4;
  localparam int          TTCD_ST_DEFAULTED  = 5;
  localparam int          TTCD_ST_TX_OK      = 6;
  localparam int          TTCD_ST_BAND_BUSY  = 7;
  localparam int          TTCD_ST_REDUCED    = 8;

  // Pin filter bits and their values after reset
  localparam int          TTCD_PIN_BUSY      = 0;
  localparam int          TTCD_PIN_TIED      = 1;
  localparam int          TTCD_PIN_REDUCED   = 2;
  localparam logic [2:0]  TTCD_PIN_RST       = 3'h3;

  // Timing
  localparam int          TTCD_PCLK_HZ       = 10000000;
  localparam int          TTCD_CORE_HZ_A     = 6553600;
  localparam int          TTCD_CORE_HZ_C     = 10000000;
  localparam int          TTCD_FREE_MS       = 85;
  localparam int          TTCD_FREE_CYC      = TTCD_FREE_MS * (TTCD_PCLK_HZ / 1000);
  localparam int          TTCD_FREE_W        = 20;
  localparam logic [2:0]  TTCD_SETTLE_CYC    = 3'h6;
  localparam logic [2:0]  TTCD_IDX_LATCH     = 3'h7;

  typedef enum logic [3:0] {
    TTCD_S_SETTLE  = 4'b0001,
    TTCD_S_LOAD    = 4'b0010,
    TTCD_S_RUN     = 4'b0100,
    TTCD_S_RESTORE = 4'b1000
  } ttcd_state_t;
endpackage
`default_nettype wire

/* logic/ttcd_decode.sv */
`timescale 1ns/10ps
`default_nettype none
module ttcd_decode
  import ttcd_pkg::*;
(
  input  wire logic [55:0] param_set,
  input  wire logic        reduced,
  output logic             band_a,
  output logic             access_en,
  output logic             pm_sel,
  output logic             matched
);
  // A-band pair differs in byte 3
  // C-band sets differ in access, pm
  always_comb begin
    band_a    = 1'b0;
    access_en = 1'b0;
    pm_sel    = 1'b0;
    matched   = 1'b1;
    case (param_set)
      TTCD_SET_C_PLAIN: begin
      end
      TTCD_SET_C_ACC: begin
        access_en = 1'b1;
      end
      TTCD_SET_C_PLAINPM: begin
        pm_sel = 1'b1;
      end
      TTCD_SET_C_ACCPM: begin
        access_en = 1'b1;
        pm_sel    = 1'b1;
      end
      TTCD_SET_A_PLAIN: begin
        band_a  = ~reduced;
        matched = ~reduced;
      end
      TTCD_SET_A_PM: begin
        band_a  = ~reduced;
        pm_sel  = ~reduced;
        matched = ~reduced;
      end
      default: begin
        matched = 1'b0;
      end
    endcase
  end
endmodule
`default_nettype wire

/* bench/ttcd_top_test.sv */
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin \
  errors++; $display("unexpected %s: expected %h seen %h", nm, ex, got); \
  end end
module ttcd_top_test
  import ttcd_pkg::*;
;
  localparam int FREE = 20;
  typedef struct packed {
    logic [55:0] set;
    logic        tied;
    logic        red;
    logic [4:0]  exp;
  } ttcd_row_t;

  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        nv_por_n = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        band_in_use = 1'b1;
  logic        supply_monitor_pin_tied = 1'b0;
  logic        reduced_variant = 1'b0;
  logic        comm_ready;
  logic        band_a;
  logic        access_en;
  logic        pm_selected;
  logic        pm_active;
  logic        core_clk_sel_a;
  logic        tx_allowed;
  logic [31:0] rd;
  logic        err;
  int          errors = 0;
  int          n_checks = 0;
  int          cyc = 0;
  int          k;
  // Expected {band_a, access, pm_sel, pm_active, defaulted}
  ttcd_row_t   rows [8] = '{
    '{TTCD_SET_FACTORY,   1'b0, 1'b0, 5'b00000},
    '{TTCD_SET_C_ACC,     1'b0, 1'b0, 5'b01000},
    '{TTCD_SET_C_PLAINPM, 1'b0, 1'b0, 5'b00110},
    '{TTCD_SET_C_ACCPM,   1'b1, 1'b0, 5'b01100},
    '{TTCD_SET_A_PLAIN,   1'b0, 1'b0, 5'b10000},
    '{TTCD_SET_A_PM,      1'b0, 1'b0, 5'b10110},
    '{TTCD_SET_A_PM,      1'b0, 1'b1, 5'b00001},
    '{56'h0E010013000000, 1'b0, 1'b0, 5'b00001}};

  ttcd_top #(.FREE_CYCLES(FREE)) dut (
    .pclk(pclk), .presetn(presetn), .nv_por_n(nv_por_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .band_in_use(band_in_use),
    .supply_monitor_pin_tied(supply_monitor_pin_tied),
    .reduced_variant(reduced_variant), .comm_ready(comm_ready),
    .band_a(band_a), .access_en(access_en), .pm_selected(pm_selected),
    .pm_active(pm_active), .core_clk_sel_a(core_clk_sel_a),
    .tx_allowed(tx_allowed));

  always #50 pclk = ~pclk;

  function automatic logic [31:0] lo_of(input logic [55:0] s);
    return {s[31:24], s[39:32], s[47:40], s[55:48]};
  endfunction
  function automatic logic [31:0] hi_of(input logic [55:0] s);
    return {8'h00, s[7:0], s[15:8], s[23:16]};
  endfunction

  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    // Only the bench timeout ends a stuck wait
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Bounded so a stuck load cannot hang the run
  task automatic wait_ready();
    int n;
    n = 0;
    while (comm_ready !== 1'b1 && n < 40) begin
      @(posedge pclk);
      n++;
    end
    `CHK("comm_ready", 1'b1, comm_ready);
    repeat (3) @(posedge pclk);
  endtask

  task automatic do_reset();
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    wait_ready();
  endtask

  task automatic load_set(input logic [55:0] s);
    apb(1'b1, TTCD_OFF_PARAM_LO, lo_of(s));
    apb(1'b1, TTCD_OFF_PARAM_HI, hi_of(s));
    do_reset();
  endtask

  task automatic test_done();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  always @(posedge pclk) begin
    cyc++;
    if (cyc == 6000) begin
      errors++;
      test_done();
    end
  end

  initial begin
    repeat (6) @(posedge pclk);
    `CHK("comm_ready", 1'b0, comm_ready);
    `CHK("pready", 1'b1, pready);
    `CHK("tx_allowed", 1'b0, tx_allowed);
    nv_por_n <= 1'b1;
    presetn <= 1'b1;
    wait_ready();
    `CHK("band_a", 1'b0, band_a);
    for (int i = 0; i < 8; i++) begin
      supply_monitor_pin_tied <= rows[i].tied;
      reduced_variant <= rows[i].red;
      load_set(rows[i].set);
      `CHK("band_a", rows[i].exp[4], band_a);
      `CHK("access_en", rows[i].exp[3], access_en);
      `CHK("pm_selected", rows[i].exp[2], pm_selected);
      `CHK("pm_active", rows[i].exp[1], pm_active);
      `CHK("core_clk_sel_a", rows[i].exp[4], core_clk_sel_a);
      `CHK("tx_allowed", ~rows[i].exp[3], tx_allowed);
      apb(1'b0, TTCD_OFF_STATUS, 32'h00000000);
      `CHK("status", {23'h000000, rows[i].red, 1'b1, ~rows[i].exp[3],
           rows[i].exp[0], rows[i].exp[1], rows[i].exp[2],
           rows[i].exp[3], rows[i].exp[4], 1'b1}, rd);
    end
    apb(1'b0, TTCD_OFF_PARAM_LO, 32'h00000000);
    `CHK("param_lo", lo_of(rows[7].set), rd);
    apb(1'b0, TTCD_OFF_PARAM_HI, 32'h00000000);
    `CHK("param_hi", hi_of(rows[7].set), rd);
    apb(1'b1, 8'h10, 32'hFFFFFFFF);
    `CHK("pslverr_wr", 1'b1, err);
    apb(1'b0, 8'h10, 32'h00000000);
    `CHK("pslverr_rd", 1'b1, err);
    `CHK("unmapped_rd", 32'h00000000, rd);
    // Free-band wait measured from the pin falling
    load_set(TTCD_SET_C_ACC);
    band_in_use <= 1'b0;
    k = 0;
    while (tx_allowed !== 1'b1 && k < 100) begin
      @(posedge pclk);
      k++;
    end
    `CHK("tx_delay_min", 1'b1, k >= FREE);
    `CHK("tx_delay_max", 1'b1, k <= FREE + 10);
    band_in_use <= 1'b1;
    repeat (8) @(posedge pclk);
    `CHK("tx_busy", 1'b0, tx_allowed);
    band_in_use <= 1'b0;
    // Node reset with byte one nonzero keeps the set
    load_set(TTCD_SET_A_PLAIN);
    apb(1'b1, TTCD_OFF_CTRL, 32'h00000001);
    repeat (2) @(posedge pclk);
    `CHK("comm_ready_drop", 1'b0, comm_ready);
    wait_ready();
    `CHK("band_a", 1'b1, band_a);
    apb(1'b1, TTCD_OFF_PARAM_LO, lo_of(TTCD_SET_C_ACC));
    apb(1'b1, TTCD_OFF_CTRL, 32'h00000001);
    repeat (2) @(posedge pclk);
    wait_ready();
    `CHK("band_a", 1'b0, band_a);
    `CHK("access_en", 1'b0, access_en);
    apb(1'b0, TTCD_OFF_PARAM_LO, 32'h00000000);
    `CHK("param_lo", lo_of(TTCD_SET_FACTORY), rd);
    apb(1'b0, TTCD_OFF_PARAM_HI, 32'h00000000);
    `CHK("param_hi", hi_of(TTCD_SET_FACTORY), rd);
    do_reset();
    `CHK("access_en", 1'b0, access_en);
    `CHK("band_a", 1'b0, band_a);
    test_done();
  end
endmodule
`default_nettype wire
